// ---- pde_pins.sv ----
// Purpose: external pins seen by the block
// Assumes: outside sources drive undriven pins
// Notes: a driven pin shows the block's value
`timescale 1ns/1ns
`default_nettype none
module pde_pins (
  input wire logic [13:0] d_out, // d drive value
  input wire logic [13:0] d_oe_n, // d enable
  input wire logic [15:0] e_out, // e drive value
  input wire logic [15:0] e_oe_n, // e enable
  input wire logic [15:0] d_ext, // outside d levels
  input wire logic [15:0] e_ext, // outside e levels
  output logic [13:0] d_pin, // resolved d
  output logic [15:0] e_pin // resolved e
);
  // resolve each wire from both drivers
  assign d_pin = (d_out & ~d_oe_n) | (d_ext[13:0] & d_oe_n);
  assign e_pin = (e_out & ~e_oe_n) | (e_ext & e_oe_n);
endmodule // pde_pins
`default_nettype wire

// ---- pde_pkg.sv ----
// Purpose: shared constants for the port d / port e data register block
// Assumes: apb slave, 32-bit data, registers in low 16 bits of a word
// Notes: register offsets are not all multiples of four, so they are kept
//   as indices and the apb byte address is four times the index
//
// Overview of operation
// - port d data register 16 bits, bits 13:0
// - port d bits 15:14 always read zero
// - general output drives stored bit, reads stored
// - direction zero reads the live pin level
// - direction zero write stores, pin unaffected
// - other function with direction one: read stored, write not driven
// - clear on power-on and hardware standby only
// - port e data register 16 bits, all used
// - port e function follows operating mode
// - output disable low floats port e general outputs, address outputs stay driven
// - port e register at its fixed index
// - every access takes five cycles
// - port d register at its fixed index
package pde_pkg;
  localparam logic [31:0] PDE_PORT_D_INDEX = 32'hFFFFF746;
  localparam logic [31:0] PDE_PORT_E_INDEX = 32'hFFFFF754;
  localparam logic [31:0] PDE_PORT_D_ADDR = 32'(PDE_PORT_D_INDEX << 2);
  localparam logic [31:0] PDE_PORT_E_ADDR = 32'(PDE_PORT_E_INDEX << 2);
  localparam logic [15:0] PDE_RESET_VALUE = 16'h0000;
  localparam logic [15:0] PDE_PORT_D_MASK = 16'h3FFF;
  localparam logic [15:0] PDE_PORT_E_MASK = 16'hFFFF;
  localparam int PDE_WIDTH = 16;
  // access takes five cycles: setup plus four access cycles
  localparam logic [1:0] PDE_ACCESS_WAITS = 2'h2;
  typedef enum logic [1:0] {
    PDE_MODE_SINGLE = 2'b00,
    PDE_MODE_ROM_ON = 2'b01,
    PDE_MODE_ROM_OFF = 2'b10
  } pde_mode_t;
endpackage : pde_pkg

// ---- pde_port_bits.sv ----
// Purpose: data bits of one port with read select and pin drive
// Assumes: direction and function inputs come from pclk logic
// Notes: output enable is low while the bit drives its pin
`timescale 1ns/1ns
`default_nettype none
module pde_port_bits #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic standby_n, // hardware standby, active low
  input wire logic [15:0] wr_data, // write data
  input wire logic [15:0] wr_bits, // per-bit write strobe
  input wire logic [15:0] direction, // 1 = output direction
  input wire logic [15:0] gp_func, // 1 = general purpose function
  input wire logic out_disable_n, // force general outputs off
  input wire logic [15:0] pin_level, // synchronised pin levels
  output logic [15:0] rd_value, // value a read returns
  output logic [15:0] pin_out, // drive value
  output logic [15:0] pin_oe_n // drive enable, active low
);
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] out;
    logic [15:0] oe_n;
  } pde_bits_t;
  pde_bits_t st, next_st;
  // per bit: store writes, set drive value from stored bit, steer driver
  always_comb begin
    next_st = st;
    for (int i = 0; i < 16; i++) begin
      if (wr_bits[i] && MASK[i]) begin
        next_st.data[i] = wr_data[i];
      end
      next_st.out[i] = next_st.data[i] & MASK[i];
      // drive only general outputs with disable released
      next_st.oe_n[i] = ~(MASK[i] & direction[i] & gp_func[i] & out_disable_n);
    end
    if (!standby_n) begin
      next_st = '{data: pde_pkg::PDE_RESET_VALUE, out: '0, oe_n: '1};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{data: pde_pkg::PDE_RESET_VALUE, out: '0, oe_n: '1};
    end else begin
      st <= next_st;
    end
  end
  // direction 0 reads pin, otherwise stored bit
  always_comb begin
    rd_value = ((direction & st.data) | (~direction & pin_level)) & MASK;
  end
  assign pin_out = st.out;
  assign pin_oe_n = st.oe_n;
endmodule // pde_port_bits
`default_nettype wire

// ---- pde_ports.sv ----
// Purpose: port d and port e data registers on an apb slave
// Assumes: direction and function registers live elsewhere, pclk domain
// Notes: port e function is overridden by operating mode
`timescale 1ns/1ns
`default_nettype none
module pde_ports (
  input wire logic pclk, // 250 MHz system clock
  input wire logic presetn, // power-on reset, active low
  input wire logic standby_n, // hardware standby, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [1:0] op_mode, // operating mode, pde_mode_t code
  input wire logic [15:0] port_d_direction_bits, // port d direction
  input wire logic [15:0] port_e_direction_bits, // port e direction
  input wire logic [15:0] port_d_gp_func, // port d general function
  input wire logic [15:0] port_e_gp_func, // port e general function
  input wire logic [15:0] addr_low, // bus address lines 15:0
  input wire logic port_output_disable_n, // output disable pin
  input wire logic [13:0] port_d_pin_in, // port d pin levels
  output logic [13:0] port_d_pin_out, // port d drive value
  output logic [13:0] port_d_pin_oe_n, // port d enable, low drives
  input wire logic [15:0] port_e_pin_in, // port e pin levels
  output logic [15:0] port_e_pin_out, // port e drive value
  output logic [15:0] port_e_pin_oe_n // port e enable, low drives
);
  typedef struct packed {
    logic [1:0] wait_cnt;
    logic ready;
    logic err;
    logic [31:0] rdata;
    logic [15:0] e_out;
    logic [15:0] e_oe_n;
    logic [1:0] mode;
  } pde_top_t;
  pde_top_t st, next_st;
  logic [15:0] d_sync, e_sync, d_rd, e_rd, d_wr, e_wr, d_out, d_oe_n, e_gp_out, e_gp_oe_n;
  logic [15:0] e_func, e_addr_sel, wr_lanes;
  logic [0:0] od_sync;
  logic hit_d, hit_e, acc_done;

  pde_sync #(.WIDTH(16)) u_sync_d (.pclk(pclk), .presetn(presetn),
    .async_in({2'b00, port_d_pin_in}), .sync_out(d_sync));
  pde_sync #(.WIDTH(16)) u_sync_e (.pclk(pclk), .presetn(presetn),
    .async_in(port_e_pin_in), .sync_out(e_sync));
  pde_sync #(.WIDTH(1)) u_sync_od (.pclk(pclk), .presetn(presetn),
    .async_in(port_output_disable_n), .sync_out(od_sync));

  // address decode at the word addresses
  always_comb begin
    hit_d = (paddr == pde_pkg::PDE_PORT_D_ADDR);
    hit_e = (paddr == pde_pkg::PDE_PORT_E_ADDR);
    acc_done = psel && penable && st.ready;
    wr_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}}; // byte or halfword writes
    d_wr = (acc_done && pwrite && hit_d) ? wr_lanes : 16'h0000;
    e_wr = (acc_done && pwrite && hit_e) ? wr_lanes : 16'h0000;
  end

  // port e function per operating mode
  always_comb begin
    case (pde_pkg::pde_mode_t'(st.mode))
      pde_pkg::PDE_MODE_ROM_OFF: begin
        e_addr_sel = 16'hFFFF;
      end
      pde_pkg::PDE_MODE_ROM_ON: begin
        e_addr_sel = ~port_e_gp_func;
      end
      pde_pkg::PDE_MODE_SINGLE: begin
        e_addr_sel = 16'h0000;
      end
      default: begin
        e_addr_sel = 16'h0000;
      end
    endcase
    e_func = port_e_gp_func & ~e_addr_sel;
  end

  pde_port_bits #(.MASK(pde_pkg::PDE_PORT_D_MASK)) u_port_d (
    .pclk(pclk), .presetn(presetn), .standby_n(standby_n),
    .wr_data(pwdata[15:0]), .wr_bits(d_wr),
    .direction(port_d_direction_bits), .gp_func(port_d_gp_func),
    .out_disable_n(1'b1), .pin_level(d_sync),
    .rd_value(d_rd), .pin_out(d_out), .pin_oe_n(d_oe_n));

  pde_port_bits #(.MASK(pde_pkg::PDE_PORT_E_MASK)) u_port_e (
    .pclk(pclk), .presetn(presetn), .standby_n(standby_n),
    .wr_data(pwdata[15:0]), .wr_bits(e_wr),
    .direction(port_e_direction_bits), .gp_func(e_func),
    .out_disable_n(od_sync[0]), .pin_level(e_sync),
    .rd_value(e_rd), .pin_out(e_gp_out), .pin_oe_n(e_gp_oe_n));

  // bus timing, pin mux and read capture
  always_comb begin
    next_st = st;
    next_st.mode = op_mode;
    // wait states give five cycles per transfer
    if (psel && penable && !st.ready) begin
      if (st.wait_cnt == pde_pkg::PDE_ACCESS_WAITS) begin
        next_st.ready = 1'b1;
        next_st.err = !(hit_d || hit_e);
        next_st.rdata = {16'h0000, hit_d ? d_rd : (hit_e ? e_rd : 16'h0000)};
      end else begin
        next_st.wait_cnt = st.wait_cnt + 2'h1;
      end
    end else begin
      next_st.ready = 1'b0;
      next_st.err = 1'b0;
      next_st.wait_cnt = 2'h0;
    end
    // address lines take the pins they own
    for (int i = 0; i < 16; i++) begin
      next_st.e_out[i] = e_addr_sel[i] ? addr_low[i] : e_gp_out[i];
      next_st.e_oe_n[i] = e_addr_sel[i] ? 1'b0 : e_gp_oe_n[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{wait_cnt: 2'h0, ready: 1'b0, err: 1'b0, rdata: 32'h00000000,
              e_out: 16'h0000, e_oe_n: 16'hFFFF, mode: 2'h0};
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign port_d_pin_out = d_out[13:0];
  assign port_d_pin_oe_n = d_oe_n[13:0];
  assign port_e_pin_out = st.e_out;
  assign port_e_pin_oe_n = st.e_oe_n;
endmodule // pde_ports
`default_nettype wire

// ---- pde_ports_checker.sv ----
// Purpose: concurrent checks on the port d / e data register block
// Assumes: sees only top-level ports
// Notes: bind statement at the foot
`timescale 1ns/1ns
`default_nettype none
module pde_ports_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic standby_n, // standby, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [31:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [1:0] op_mode, // mode
  input wire logic [15:0] port_d_direction_bits, // d direction
  input wire logic [15:0] port_d_gp_func, // d function
  input wire logic port_output_disable_n, // disable pin
  input wire logic [13:0] port_d_pin_oe_n, // d enable
  input wire logic [15:0] port_e_pin_oe_n // e enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus timing and decode
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  access_len_a: assert property (psel && penable && !$past(penable) |->
    !pready ##1 !pready ##1 !pready ##1 pready) else $error("access not five cycles");
  map_err_a: assert property (pready |-> pslverr == !(paddr == pde_pkg::PDE_PORT_D_ADDR ||
    paddr == pde_pkg::PDE_PORT_E_ADDR)) else $error("decode error flag wrong");
  d_rsvd_a: assert property (pready && !pwrite && paddr == pde_pkg::PDE_PORT_D_ADDR |->
    prdata[15:14] == 2'h0) else $error("reserved d bits nonzero");
  // pin drive
  standby_off_a: assert property (!standby_n |=> port_d_pin_oe_n == 14'h3FFF)
    else $error("standby left d driving");
  d_nodrive_a: assert property (((port_d_direction_bits & port_d_gp_func) == 16'h0000)[*4]
    |-> port_d_pin_oe_n == 14'h3FFF) else $error("d pin driven");
  e_float_a: assert property ((!port_output_disable_n && op_mode == 2'h0)[*7]
    |-> port_e_pin_oe_n == 16'hFFFF) else $error("e not floated");
  rom_off_a: assert property ((op_mode == 2'h2 && standby_n)[*4]
    |-> port_e_pin_oe_n == 16'h0000) else $error("e address not driven");
endmodule // pde_ports_checker
bind pde_ports pde_ports_checker chk_i (.pclk, .presetn, .standby_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .op_mode, .port_d_direction_bits, .port_d_gp_func,
  .port_output_disable_n, .port_d_pin_oe_n, .port_e_pin_oe_n);
`default_nettype wire

// ---- pde_sync.sv ----
// Purpose: three flip-flop synchroniser with agreement filter for pins
// Assumes: inputs asynchronous to pclk
// Notes: output changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pde_sync #(
  parameter int WIDTH = 16
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // filtered levels
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } pde_sync_t;
  pde_sync_t st, next_st;
  // stage one is read only by stage two
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign sync_out = st.q;
endmodule // pde_sync
`default_nettype wire

// ---- tb.sv ----
// Purpose: self-checking bench for the port d / e registers
// Assumes: apb master, pins from pde_pins
// Notes: read results checked from a queue
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [31:0] DA = pde_pkg::PDE_PORT_D_ADDR;
  localparam logic [31:0] EA = pde_pkg::PDE_PORT_E_ADDR;
  logic pclk = 1'b0, presetn = 1'b0, standby_n = 1'b1, pod_n = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] op_mode = 2'h0;
  logic [15:0] d_dir = 16'h0, e_dir = 16'h0, d_gp = 16'hFFFF, e_gp = 16'hFFFF;
  logic [15:0] addr_low = 16'h0, d_ext = 16'h0, e_ext = 16'h0, e_out, e_oe_n, e_pin;
  logic [13:0] d_out, d_oe_n, d_pin;
  logic [32:0] exp_q[$];
  int bad_count = 0, cmp_count = 0;
  pde_ports dut (.pclk, .presetn, .standby_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .op_mode, .port_d_direction_bits(d_dir),
    .port_e_direction_bits(e_dir), .port_d_gp_func(d_gp), .port_e_gp_func(e_gp), .addr_low,
    .port_output_disable_n(pod_n), .port_d_pin_in(d_pin), .port_d_pin_out(d_out),
    .port_d_pin_oe_n(d_oe_n), .port_e_pin_in(e_pin), .port_e_pin_out(e_out),
    .port_e_pin_oe_n(e_oe_n));
  pde_pins pins (.d_out, .d_oe_n, .e_out, .e_oe_n, .d_ext, .e_ext, .d_pin, .e_pin);
  initial forever #2 pclk = ~pclk;
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    // a note left in the queue is a read that never got checked
    if (exp_q.size() != 0) bad_count++;
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 16'h0000, 4'h0);
  endtask
  // oldest note checked when a read completes
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    void'($urandom(32'h4fdc1bb0));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(DA, 33'h0);
    rd(EA, 33'h0);
    // direction zero: read shows pin, write stays inside
    r = $urandom;
    d_ext <= r[15:0];
    apb(1'b1, DA, ~r[15:0], 4'h3);
    repeat (8) @(posedge pclk);
    rd(DA, {19'h0, r[13:0]});
    chk({19'h0, d_oe_n}, 33'h3FFF);
    // general output: stored value read and driven
    d_dir <= 16'hFFFF;
    rd(DA, {17'h0, ~r[15:0] & 16'h3FFF});
    repeat (4) begin
      r = $urandom;
      apb(1'b1, DA, r[15:0], 4'h3);
      rd(DA, {17'h0, r[15:0] & 16'h3FFF});
      chk({5'h0, d_oe_n, d_out}, {19'h0, r[13:0]});
    end
    // other function: stored value read, pin left alone
    d_gp <= 16'h0000;
    r = $urandom;
    d_ext <= ~r[15:0];
    apb(1'b1, DA, r[15:0], 4'h3);
    repeat (8) @(posedge pclk);
    rd(DA, {17'h0, r[15:0] & 16'h3FFF});
    chk({19'h0, d_oe_n}, 33'h3FFF);
    // port e byte write, then output disable
    e_dir <= 16'hFFFF;
    apb(1'b1, EA, 16'hFFFF, 4'h3);
    apb(1'b1, EA, 16'h1234, 4'h1);
    rd(EA, {17'h0, 16'hFF34});
    pod_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({17'h0, e_oe_n}, 33'h0FFFF);
    pod_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({1'h0, e_oe_n, e_out}, {17'h0, 16'hFF34});
    rd(32'h0000_0010, {1'b1, 32'h0});
    // address function by mode
    r = $urandom;
    addr_low <= r[15:0];
    d_gp <= 16'hFFFF;
    op_mode <= 2'h2;
    repeat (5) @(posedge pclk);
    chk({1'h0, e_oe_n, e_out}, {17'h0, r[15:0]});
    e_gp <= 16'h00FF;
    op_mode <= 2'h1;
    repeat (5) @(posedge pclk);
    chk({1'h0, e_oe_n, e_out}, {17'h0, r[15:8], 8'h34});
    op_mode <= 2'h0;
    // hardware standby clears both
    standby_n <= 1'b0;
    @(posedge pclk) standby_n <= 1'b1;
    rd(DA, 33'h0);
    rd(EA, 33'h0);
    repeat (2) @(posedge pclk);
    end_sim();
  end
endmodule // tb
`default_nettype wire
